// ==== framer_model.sv ====
// framer model: transmit clock and rail data for the line unit
`timescale 1ns/10ps
module framer_model (
  input  wire logic        run,     // 1: transmit clock runs
  input  wire logic [15:0] pos_pat, // positive or NRZ bits, bit 0 first
  input  wire logic [15:0] neg_pat, // negative rail bits
  input  wire logic [4:0]  len,     // pattern length in bits, not 0
  output logic             tx_clk,  // 320 ns transmit clock
  output logic             pos,     // positive or NRZ data
  output logic             neg      // negative data
);
  int idx;
  initial begin
    tx_clk = 1'h0;
    pos = 1'h0;
    neg = 1'h0;
    idx = 0;
    #7;
    forever begin
      #160;
      // the clock stands still while run is low
      if (run) begin
        tx_clk = ~tx_clk;
        // data moves on the falling edge so it is stable at the rising one
        if (!tx_clk) begin
          pos = pos_pat[idx];
          neg = neg_pat[idx];
          idx = (idx + 1) % len;
        end
      end
    end
  end
endmodule

// ==== line_code_if.sv ====
// carrier between the channel control and its line encoder
`timescale 1ns/10ps
interface line_code_if;
  logic tick;
  logic single_rail;
  logic e3_rate;
  logic pos_in;
  logic neg_in;
  logic pos_out;
  logic neg_out;

  modport enc (input tick, single_rail, e3_rate, pos_in, neg_in,
               output pos_out, neg_out);
  modport ctl (output tick, single_rail, e3_rate, pos_in, neg_in,
               input pos_out, neg_out);
endinterface

// ==== line_encoder.sv ====
// zero-substitution line encoder with dual-rail bypass
`timescale 1ns/10ps
module line_encoder (
  input  wire logic      clk,     // system clock
  input  wire logic      resetn,  // synchronous reset, active low
  line_code_if.enc       bus      // ticks, format and rail data
);
  lineunit_pkg::sym_type pipe      [lineunit_pkg::HDB3_RUN];
  lineunit_pkg::sym_type next_pipe [lineunit_pkg::HDB3_RUN];
  logic                  parity;
  logic                  next_parity;
  logic                  last_pos;
  logic                  next_last_pos;
  logic                  pos_q;
  logic                  next_pos;
  logic                  neg_q;
  logic                  next_neg;
  logic                  sub_now;

  assign bus.pos_out = pos_q;
  assign bus.neg_out = neg_q;

  always_comb begin
    int run;
    run           = bus.e3_rate ? lineunit_pkg::HDB3_RUN
                                : lineunit_pkg::B3ZS_RUN;
    next_pipe     = pipe;
    next_parity   = parity;
    next_last_pos = last_pos;
    next_pos      = pos_q;
    next_neg      = neg_q;
    sub_now       = 1'b0;
    if (bus.tick) begin
      if (!bus.single_rail) begin
        // violations in the framer data go out as plain pulses
        next_pos = bus.pos_in; // [RQ3] [RQ4]
        next_neg = bus.neg_in; // [RQ4]
      end else begin
        // oldest symbol of the active window goes to the line
        case (pipe[run-1])
          lineunit_pkg::SYM_MARK, lineunit_pkg::SYM_BAL: begin
            next_pos      = ~last_pos; // [RQ22]
            next_neg      = last_pos;
            next_last_pos = ~last_pos;
          end
          lineunit_pkg::SYM_VIOL: begin
            next_pos = last_pos; // [RQ2]
            next_neg = ~last_pos;
          end
          default: begin
            next_pos = 1'b0;
            next_neg = 1'b0;
          end
        endcase
        for (int i = lineunit_pkg::HDB3_RUN - 1; i > 0; i--) begin
          next_pipe[i] = pipe[i-1];
        end
        next_pipe[0] = bus.pos_in ? lineunit_pkg::SYM_MARK
                                  : lineunit_pkg::SYM_ZERO;
        if (bus.pos_in) begin
          next_parity = ~parity;
        end
        sub_now = 1'b1;
        for (int i = 0; i < lineunit_pkg::HDB3_RUN; i++) begin
          if (i < run && next_pipe[i] != lineunit_pkg::SYM_ZERO) begin
            sub_now = 1'b0;
          end
        end
        if (sub_now) begin
          // even mark count since last violation needs a balancing pulse
          if (!parity) begin
            next_pipe[run-1] = lineunit_pkg::SYM_BAL; // [RQ2] [RQ22]
          end
          next_pipe[0] = lineunit_pkg::SYM_VIOL; // [RQ1] [RQ20]
          next_parity  = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < lineunit_pkg::HDB3_RUN; i++) begin
        pipe[i] <= lineunit_pkg::SYM_ZERO;
      end
      parity   <= 1'b0;
      last_pos <= 1'b0;
      pos_q    <= 1'b0;
      neg_q    <= 1'b0;
    end else begin
      pipe     <= next_pipe;
      parity   <= next_parity;
      last_pos <= next_last_pos;
      pos_q    <= next_pos;
      neg_q    <= next_neg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_subst_viol;
    @(posedge clk) disable iff (!resetn)
    (bus.tick && bus.single_rail && sub_now)
      |=> (pipe[0] == lineunit_pkg::SYM_VIOL && !parity);
  endproperty
  a_subst_viol: assert property (p_subst_viol) // [RQ1]
    else $error("zero run not replaced by a violation");

  property p_bal_on_even;
    @(posedge clk) disable iff (!resetn)
    (bus.tick && bus.single_rail && sub_now && !parity)
      |=> (($past(bus.e3_rate) ? pipe[3] : pipe[2])
           == lineunit_pkg::SYM_BAL);
  endproperty
  a_bal_on_even: assert property (p_bal_on_even) // [RQ2]
    else $error("balancing pulse missing on even mark count");

  property p_viol_polarity;
    @(posedge clk) disable iff (!resetn)
    (bus.tick && bus.single_rail &&
     pipe[bus.e3_rate ? 3 : 2] == lineunit_pkg::SYM_VIOL)
      |=> (pos_q == $past(last_pos) && neg_q == !$past(last_pos));
  endproperty
  a_viol_polarity: assert property (p_viol_polarity) // [RQ2]
    else $error("violation pulse polarity wrong");

  property p_dual_pass;
    @(posedge clk) disable iff (!resetn)
    (bus.tick && !bus.single_rail)
      |=> (pos_q == $past(bus.pos_in) && neg_q == $past(bus.neg_in));
  endproperty
  a_dual_pass: assert property (p_dual_pass) // [RQ4]
    else $error("dual rail data not passed through");
endmodule

// ==== lineunit_hdb3_tx_rx_control.sv ====
// per-channel transmit and receive control of a line interface unit
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
// How it works
// [RQ1] single-rail HDB3 replaces four zeros by 000V or B00V
// [RQ2] pattern choice keeps an odd mark count between violations
// [RQ3] dual-rail format bypasses the substitution encoder
// [RQ4] dual-rail violations go to the line as ordinary pulses
// [RQ5] build-out enabled when its control is 0, disabled at 1
// [RQ6] E3 rate always keeps build-out disabled
// [RQ7] far side: enable build-out below 225 feet, else disable
// [RQ8] drive fault flag low while monitor inputs keep toggling
// [RQ9] no monitor transition for 128 tx clocks raises the fault flag
// [RQ10] transmitter on by pin, or host bit 1 with pin high
// [RQ11] transmitter off tristates both line outputs
// [RQ12] host bit at 1 hands on/off control to the pin
// [RQ13] equalizer in when its control is 1, out at 0
// [RQ14] far side: bypass equalizer for square pulses under 300 feet
// [RQ15] monitor control 1 switches in the extra 20 dB gain
// [RQ16] monitor mode suppresses loss of signal entirely
// [RQ17] no input or clock off by over 0.5 percent declares lock loss
// [RQ18] during lock loss the rx clock carries the reference clock
// [RQ19] host control bit 0 at 1 selects single rail, 0 dual rail
// [RQ20] DS3/STS-1 rates replace three zeros by B0V or 00V
// [RQ21] locked with input present, rx clock carries recovered clock
// [RQ22] even mark parity gives B00V, odd gives 000V; marks alternate
module lineunit_hdb3_tx_rx_control #(
  parameter int LOCK_WINDOW = lineunit_pkg::LOCK_WINDOW
) (
  input  wire logic       clk,                // 25 MHz system clock
  input  wire logic       resetn,             // sync reset, active low
  input  wire logic [3:0] addr,               // register address
  input  wire logic [7:0] wdata,              // register write data
  input  wire logic       wr,                 // write strobe
  input  wire logic       rd,                 // read strobe
  output logic      [7:0] rdata,              // read data, cycle after rd
  input  wire logic       host_mode,          // 1: registers, 0: pins
  input  wire logic       rail_format_select, // pin: 1 single rail
  input  wire logic       build_out_disable,  // pin: 1 disables build-out
  input  wire logic       transmitter_on,     // pin: transmitter on
  input  wire logic       rx_equalizer_in,    // pin: equalizer in
  input  wire logic       rx_monitor_gain,    // pin: monitor gain on
  input  wire logic       e3_rate_select,     // pin: 1 E3, 0 DS3/STS-1
  input  wire logic       tx_line_clock,      // framer transmit clock
  input  wire logic       tx_positive_data,   // positive or NRZ data
  input  wire logic       tx_negative_data,   // negative data
  input  wire logic       monitor_plus_input, // drive monitor plus
  input  wire logic       monitor_minus_input,// drive monitor minus
  input  wire logic       line_in_plus,       // sliced rx positive
  input  wire logic       line_in_minus,      // sliced rx negative
  input  wire logic       reference_clock_in, // external reference clock
  input  wire logic       recovered_clock_in, // recovered line clock
  output logic            line_out_plus,      // line driver plus
  output logic            line_out_minus,     // line driver minus
  output logic            line_out_oe,        // driver enable, 0 tristate
  output logic            build_out_on,       // build-out circuit enable
  output logic            rx_equalizer_on,    // equalizer switched in
  output logic            rx_monitor_on,      // 20 dB gain stage on
  output logic            drive_fault_flag,   // no drive monitor transitions
  output logic            rx_lock_lost,       // loss of lock
  output logic            los_flag,           // loss of signal
  output logic            rx_clock_out        // receive clock output
);
  localparam int CNT_W   = $clog2(LOCK_WINDOW) + 2;
  localparam int IDLE_W  = $clog2(lineunit_pkg::DRIVE_IDLE_PERIODS) + 1;
  localparam int TOL     = LOCK_WINDOW * lineunit_pkg::LOCK_TOL_PER_MILLE
                           / lineunit_pkg::PER_MILLE;

  line_code_if enc_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers; stage one is read by stage two only
  logic [lineunit_pkg::SYNC_W-1:0] sync_a;
  logic [lineunit_pkg::SYNC_W-1:0] sync_b;
  logic [lineunit_pkg::SYNC_W-1:0] prev_b;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync_a <= '0;
      sync_b <= '0;
      prev_b <= '0;
    end else begin
      sync_a <= {e3_rate_select, rx_monitor_gain, rx_equalizer_in,
                 transmitter_on, build_out_disable, rail_format_select,
                 host_mode, recovered_clock_in, reference_clock_in,
                 line_in_minus, line_in_plus, monitor_minus_input,
                 monitor_plus_input, tx_negative_data, tx_positive_data,
                 tx_line_clock};
      sync_b <= sync_a;
      prev_b <= sync_b;
    end
  end

  logic s_tx_line_clock, s_tpos, s_tneg, s_ref, s_rec, s_host;
  logic s_rail, s_bodis, s_transmitter_on, s_eq, s_mon, s_e3;
  logic tx_edge, ref_edge, rec_edge, mon_trans, line_trans;

  assign s_tx_line_clock    = sync_b[0];
  assign s_tpos     = sync_b[1];
  assign s_tneg     = sync_b[2];
  assign s_ref      = sync_b[7];
  assign s_rec      = sync_b[8];
  assign s_host     = sync_b[9];
  assign s_rail     = sync_b[10];
  assign s_bodis    = sync_b[11];
  assign s_transmitter_on     = sync_b[12];
  assign s_eq       = sync_b[13];
  assign s_mon      = sync_b[14];
  assign s_e3       = sync_b[15];
  assign tx_edge    = s_tx_line_clock & ~prev_b[0];
  assign ref_edge   = s_ref & ~prev_b[7];
  assign rec_edge   = s_rec & ~prev_b[8];
  assign mon_trans  = |(sync_b[4:3] ^ prev_b[4:3]);
  assign line_trans = |(sync_b[6:5] ^ prev_b[6:5]);

  ////////////////////////////////////////////////////////////////////////////
  // register file and effective controls
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic [7:0] next_rdata;
  logic [7:0] status;
  logic       single_rail_eff, e3_eff, tx_on_eff, mon_eff, eq_eff;
  logic       bo_dis_eff;

  always_comb begin
    single_rail_eff = s_host ? ctrl[lineunit_pkg::CTRL_SINGLE_RAIL]
                             : s_rail; // [RQ19]
    e3_eff          = s_host ? ctrl[lineunit_pkg::CTRL_E3_RATE] : s_e3;
    bo_dis_eff      = s_host ? ctrl[lineunit_pkg::CTRL_BUILD_OUT_DIS]
                             : s_bodis;
    // host bit at 1 only arms the transmitter; the pin still switches it
    tx_on_eff       = s_host ? (ctrl[lineunit_pkg::CTRL_TX_ON] & s_transmitter_on)
                             : s_transmitter_on; // [RQ10] [RQ12]
    eq_eff          = s_host ? ctrl[lineunit_pkg::CTRL_EQ_IN] : s_eq;
    mon_eff         = s_host ? ctrl[lineunit_pkg::CTRL_MON_GAIN] : s_mon;
    status          = 8'h00;
    status[lineunit_pkg::STAT_LOCK_LOST]   = rx_lock_lost;
    status[lineunit_pkg::STAT_DRIVE_FAULT] = drive_fault_flag;
    status[lineunit_pkg::STAT_LOS]         = los_flag;
    status[lineunit_pkg::STAT_TX_ACTIVE]   = line_out_oe;
    next_ctrl  = ctrl;
    next_rdata = 8'h00;
    if (wr && addr == lineunit_pkg::CTRL_ADDR) begin
      next_ctrl = wdata;
    end
    if (rd) begin
      case (addr)
        lineunit_pkg::CTRL_ADDR:   next_rdata = ctrl;
        lineunit_pkg::STATUS_ADDR: next_rdata = status;
        default:                   next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl  <= lineunit_pkg::CTRL_RESET;
      rdata <= 8'h00;
    end else begin
      ctrl  <= next_ctrl;
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit path
  assign enc_bus.tick        = tx_edge;
  assign enc_bus.single_rail = single_rail_eff; // [RQ3]
  assign enc_bus.e3_rate     = e3_eff; // [RQ20]
  assign enc_bus.pos_in      = s_tpos;
  assign enc_bus.neg_in      = s_tneg;

  line_encoder u_encoder (
    .clk    (clk),
    .resetn (resetn),
    .bus    (enc_bus)
  );

  logic [IDLE_W-1:0] idle_cnt;
  logic [IDLE_W-1:0] next_idle_cnt;
  logic              next_fault;
  logic              next_plus, next_minus, next_oe, next_bo;

  always_comb begin
    next_oe    = tx_on_eff;
    next_plus  = tx_on_eff & enc_bus.pos_out; // [RQ11]
    next_minus = tx_on_eff & enc_bus.neg_out; // [RQ11]
    // E3 has no cross-connect template, so build-out stays off
    next_bo    = ~bo_dis_eff & ~e3_eff; // [RQ5] [RQ6]
    next_idle_cnt = idle_cnt;
    next_fault    = drive_fault_flag;
    if (mon_trans) begin
      next_idle_cnt = '0; // [RQ8]
      next_fault    = 1'b0; // [RQ8] [RQ9]
    end else if (tx_edge &&
                 idle_cnt < IDLE_W'(lineunit_pkg::DRIVE_IDLE_PERIODS)) begin
      next_idle_cnt = idle_cnt + 1'b1;
      if (idle_cnt == IDLE_W'(lineunit_pkg::DRIVE_IDLE_PERIODS - 1)) begin
        next_fault = 1'b1; // [RQ9]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      line_out_plus    <= 1'b0;
      line_out_minus   <= 1'b0;
      line_out_oe      <= 1'b0;
      build_out_on     <= 1'b0;
      idle_cnt         <= '0;
      drive_fault_flag <= 1'b0;
    end else begin
      line_out_plus    <= next_plus;
      line_out_minus   <= next_minus;
      line_out_oe      <= next_oe;
      build_out_on     <= next_bo;
      idle_cnt         <= next_idle_cnt;
      drive_fault_flag <= next_fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive path: lock check over a window of reference periods
  logic [CNT_W-1:0] win_cnt, next_win_cnt, rec_cnt, next_rec_cnt;
  logic [CNT_W-1:0] diff;
  logic             line_act, next_line_act, win_end;
  logic             next_lock_lost, next_los, next_rx_clock_out;

  always_comb begin
    win_end = ref_edge && win_cnt == CNT_W'(LOCK_WINDOW - 1);
    diff    = (rec_cnt > CNT_W'(LOCK_WINDOW))
              ? rec_cnt - CNT_W'(LOCK_WINDOW)
              : CNT_W'(LOCK_WINDOW) - rec_cnt;
    next_win_cnt   = ref_edge ? win_cnt + 1'b1 : win_cnt;
    next_rec_cnt   = rec_edge ? rec_cnt + 1'b1 : rec_cnt;
    next_line_act  = line_act | line_trans;
    next_lock_lost = rx_lock_lost;
    next_los       = los_flag;
    if (win_end) begin
      next_lock_lost = ~line_act | (diff > CNT_W'(TOL)); // [RQ17] [RQ21]
      next_los       = ~line_act;
      next_win_cnt   = '0;
      next_rec_cnt   = '0;
      next_line_act  = 1'b0;
    end
    if (mon_eff) begin
      next_los = 1'b0; // [RQ16]
    end
    // the reference stands in for the line clock while unlocked
    next_rx_clock_out = rx_lock_lost ? s_ref : s_rec; // [RQ18] [RQ21]
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      win_cnt         <= '0;
      rec_cnt         <= '0;
      line_act        <= 1'b0;
      rx_lock_lost    <= 1'b1;
      los_flag        <= 1'b0;
      rx_clock_out    <= 1'b0;
      rx_equalizer_on <= 1'b0;
      rx_monitor_on   <= 1'b0;
    end else begin
      win_cnt         <= next_win_cnt;
      rec_cnt         <= next_rec_cnt;
      line_act        <= next_line_act;
      rx_lock_lost    <= next_lock_lost;
      los_flag        <= next_los;
      rx_clock_out    <= next_rx_clock_out;
      rx_equalizer_on <= eq_eff; // [RQ13]
      rx_monitor_on   <= mon_eff; // [RQ15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_fault_clear;
    @(posedge clk) disable iff (!resetn)
    mon_trans |=> !drive_fault_flag && idle_cnt == '0;
  endproperty
  a_fault_clear: assert property (p_fault_clear) // [RQ8]
    else $error("drive fault flag not cleared by a transition");

  property p_fault_set;
    @(posedge clk) disable iff (!resetn)
    (tx_edge && !mon_trans &&
     idle_cnt == IDLE_W'(lineunit_pkg::DRIVE_IDLE_PERIODS - 1))
      |=> drive_fault_flag;
  endproperty
  a_fault_set: assert property (p_fault_set) // [RQ9]
    else $error("drive fault flag missing after idle timeout");

  property p_tx_off;
    @(posedge clk) disable iff (!resetn)
    !tx_on_eff |=> !line_out_oe && !line_out_plus && !line_out_minus;
  endproperty
  a_tx_off: assert property (p_tx_off) // [RQ11]
    else $error("line driven while transmitter is off");

  property p_host_pin_rules;
    @(posedge clk) disable iff (!resetn)
    (s_host && ctrl[lineunit_pkg::CTRL_TX_ON])
      |=> line_out_oe == $past(s_transmitter_on);
  endproperty
  a_host_pin_rules: assert property (p_host_pin_rules) // [RQ12]
    else $error("transmitter does not follow the on pin");

  property p_e3_no_build_out;
    @(posedge clk) disable iff (!resetn)
    e3_eff |=> !build_out_on;
  endproperty
  a_e3_no_build_out: assert property (p_e3_no_build_out) // [RQ6]
    else $error("build-out enabled at E3 rate");

  property p_monitor_no_los;
    @(posedge clk) disable iff (!resetn)
    mon_eff |=> rx_monitor_on && !los_flag;
  endproperty
  a_monitor_no_los: assert property (p_monitor_no_los) // [RQ16]
    else $error("loss of signal shown in monitor mode");

  property p_rx_clock_out_ref;
    @(posedge clk) disable iff (!resetn)
    rx_lock_lost |=> rx_clock_out == $past(s_ref);
  endproperty
  a_rx_clock_out_ref: assert property (p_rx_clock_out_ref) // [RQ18]
    else $error("rx clock not the reference while unlocked");

  property p_idle_lock;
    @(posedge clk) disable iff (!resetn)
    (win_end && !line_act) |=> rx_lock_lost;
  endproperty
  a_idle_lock: assert property (p_idle_lock) // [RQ17]
    else $error("lock loss not declared without input");

  c_fault: cover property (@(posedge clk) disable iff (!resetn)
    $rose(drive_fault_flag));
  c_lock: cover property (@(posedge clk) disable iff (!resetn)
    $fell(rx_lock_lost));
  c_tx_on: cover property (@(posedge clk) disable iff (!resetn)
    s_host ##1 $rose(line_out_oe));
endmodule

// ==== lineunit_pkg.sv ====
// constants, register map and symbol types for the line unit channel control
package lineunit_pkg;
  localparam int          ADDR_W             = 4;
  localparam int          DATA_W             = 8;
  localparam logic [3:0]  CTRL_ADDR          = 4'h0;
  localparam logic [3:0]  STATUS_ADDR        = 4'h1;
  localparam logic [7:0]  CTRL_RESET         = 8'h00;
  // control register bit positions
  localparam int          CTRL_SINGLE_RAIL   = 0;
  localparam int          CTRL_BUILD_OUT_DIS = 1;
  localparam int          CTRL_TX_ON         = 2;
  localparam int          CTRL_EQ_IN         = 3;
  localparam int          CTRL_MON_GAIN      = 4;
  localparam int          CTRL_E3_RATE       = 5;
  // status register bit positions
  localparam int          STAT_LOCK_LOST     = 0;
  localparam int          STAT_DRIVE_FAULT   = 1;
  localparam int          STAT_LOS           = 2;
  localparam int          STAT_TX_ACTIVE     = 3;
  // zero run lengths that trigger a substitution
  localparam int          HDB3_RUN           = 4;
  localparam int          B3ZS_RUN           = 3;
  // drive monitor timeout in transmit clock periods
  localparam int          DRIVE_IDLE_PERIODS = 128;
  // lock check window in reference clock periods and tolerance
  localparam int          LOCK_WINDOW        = 1024;
  localparam int          LOCK_TOL_PER_MILLE = 5;
  localparam int          PER_MILLE          = 1000;
  // number of inputs that pass the two-stage synchroniser
  localparam int          SYNC_W             = 16;

  typedef enum logic [1:0] {
    SYM_ZERO,
    SYM_MARK,
    SYM_VIOL,
    SYM_BAL
  } sym_type;
endpackage

// ==== test_lineunit_hdb3_tx_rx_control.sv ====
// self-checking bench for the line unit channel control
`timescale 1ns/10ps
module test_lineunit_hdb3_tx_rx_control;
  logic        clk, resetn, wr, rd, host_mode, rail_format_select;
  logic        build_out_disable, transmitter_on, rx_equalizer_in;
  logic        rx_monitor_gain, e3_rate_select, monitor_plus_input;
  logic        monitor_minus_input, line_in_plus, line_in_minus, act;
  logic        reference_clock_in, recovered_clock_in, run, tog;
  logic        tx_line_clock, tx_positive_data, tx_negative_data;
  logic        line_out_plus, line_out_minus, line_out_oe, los_flag;
  logic        build_out_on, rx_equalizer_on, rx_monitor_on;
  logic        drive_fault_flag, rx_lock_lost, rx_clock_out;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata, d;
  logic [15:0] pos_pat, neg_pat;
  logic [4:0]  len;
  int          bad_count, total_checks, n, m;
  logic [7:0]  cv [5] = '{8'h00, 8'h02, 8'h20, 8'h0C, 8'h10};
  logic [3:0]  ev [5] = '{4'h8, 4'h0, 4'h0, 4'hD, 4'hA};
  wire  [3:0]  outs = {build_out_on, rx_equalizer_on, rx_monitor_on,
                       line_out_oe};
  lineunit_hdb3_tx_rx_control #(.LOCK_WINDOW(256))
    i_lineunit_hdb3_tx_rx_control (.clk, .resetn, .addr, .wdata, .wr,
    .rd, .rdata, .host_mode, .rail_format_select, .build_out_disable,
    .transmitter_on, .rx_equalizer_in, .rx_monitor_gain, .e3_rate_select,
    .tx_line_clock, .tx_positive_data, .tx_negative_data,
    .monitor_plus_input, .monitor_minus_input, .line_in_plus,
    .line_in_minus, .reference_clock_in, .recovered_clock_in,
    .line_out_plus, .line_out_minus, .line_out_oe, .build_out_on,
    .rx_equalizer_on, .rx_monitor_on, .drive_fault_flag, .rx_lock_lost,
    .los_flag, .rx_clock_out);
  framer_model i_framer_model (.run, .pos_pat, .neg_pat, .len,
    .tx_clk(tx_line_clock), .pos(tx_positive_data), .neg(tx_negative_data));
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // recovered clock runs inverted to the reference, so the two tell apart
  initial begin
    {reference_clock_in, line_in_plus} = 2'h0;
    #3;
    forever begin
      #320;
      reference_clock_in = ~reference_clock_in;
      if (act) line_in_plus = ~line_in_plus;
    end
  end
  assign recovered_clock_in = ~reference_clock_in;
  always @(posedge clk) begin
    if (tog) monitor_plus_input <= ~monitor_plus_input;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 v = rdata;
  endtask
  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim,
                          output int c);
    c = 0;
    while (s !== v) begin
      @(posedge clk) #1 c++;
      if (c > lim) begin
        check(s, v);
        final_report();
      end
    end
  endtask
  // samples 64 times at a stride of 5, so every phase of the clock is seen
  task automatic follow(output int c);
    logic r;
    c = 0;
    repeat (64) begin
      repeat (2) @(posedge clk);
      #1 r = reference_clock_in;
      repeat (3) @(posedge clk);
      #1 c += (rx_clock_out === r);
    end
  endtask
  // captures ten line symbols from the first negative after a positive
  task automatic cc(input logic [1:0] fr, input logic [15:0] p, q,
                    input logic [4:0] l, input logic [15:0] ep, em);
    logic [15:0] sp, sn;
    int i, lp;
    {sp, sn, i, lp} = '0;
    @(posedge clk);
    {rail_format_select, e3_rate_select} <= fr;
    {pos_pat, neg_pat, len} <= {p, q, l};
    repeat (12) @(posedge tx_line_clock);
    for (int k = 0; k < 40 && i < 10; k++) begin
      @(posedge tx_line_clock);
      #280;
      if (i > 0 || (line_out_minus && !line_out_plus && lp)) begin
        sp[i] = line_out_plus;
        sn[i] = line_out_minus;
        i++;
      end
      lp |= line_out_plus;
    end
    check(sp, ep);
    check(sn, em);
  endtask
  initial begin
    {resetn, wr, rd, host_mode, rail_format_select} = 5'h00;
    {build_out_disable, transmitter_on, rx_equalizer_in} = 3'h0;
    {rx_monitor_gain, e3_rate_select, monitor_plus_input} = 3'h0;
    {monitor_minus_input, line_in_minus, act, tog, addr, wdata} = 16'h0;
    {pos_pat, neg_pat, len} = 37'h10;
    {bad_count, total_checks, run} = 65'h1;
    repeat (20) @(posedge clk);
    #1 check({line_out_oe, rx_lock_lost}, 16'h1);
    resetn <= 1'h1;
    rreg(lineunit_pkg::CTRL_ADDR, d);
    check(d, lineunit_pkg::CTRL_RESET);
    wreg(lineunit_pkg::CTRL_ADDR, 8'h2D);
    rreg(lineunit_pkg::CTRL_ADDR, d);
    check(d, 8'h2D);
    wreg(lineunit_pkg::STATUS_ADDR, 8'hFF);
    rreg(lineunit_pkg::STATUS_ADDR, d);
    check(d[7:4], 16'h0);
    rreg(4'hF, d);
    check(d, 16'h0);
    {host_mode, transmitter_on} <= 2'h3;
    wreg(lineunit_pkg::CTRL_ADDR, 8'h00);
    wait_for(los_flag, 1'h1, 9000, n);
    for (int k = 0; k < 5; k++) begin
      wreg(lineunit_pkg::CTRL_ADDR, cv[k]);
      settle();
      check(outs, ev[k]);
    end
    check(los_flag, 16'h0);
    wreg(lineunit_pkg::CTRL_ADDR, 8'h25);
    transmitter_on <= 1'h0;
    settle();
    check({line_out_oe, line_out_plus, line_out_minus}, 16'h0);
    transmitter_on <= 1'h1;
    settle();
    rreg(lineunit_pkg::STATUS_ADDR, d);
    check({line_out_oe, d[3]}, 16'h3);
    tog <= 1'h1;
    repeat (300) @(posedge clk);
    #1 check(drive_fault_flag, 16'h0);
    tog <= 1'h0;
    wait_for(drive_fault_flag, 1'h1, 1400, n);
    check(n >= 760 && n <= 1300, 16'h1);
    tog <= 1'h1;
    wait_for(drive_fault_flag, 1'h0, 8, n);
    host_mode <= 1'h0;
    cc(2'h3, 16'h0000, 16'h0000, 5'h10, 16'h0090, 16'h0109);
    cc(2'h3, 16'h0001, 16'h0000, 5'h05, 16'h0220, 16'h0011);
    cc(2'h2, 16'h0000, 16'h0000, 5'h10, 16'h0228, 16'h0145);
    cc(2'h2, 16'h0001, 16'h0000, 5'h04, 16'h0090, 16'h0109);
    cc(2'h1, 16'h0003, 16'h0008, 5'h08, 16'h0060, 16'h0101);
    act <= 1'h1;
    wait_for(rx_lock_lost, 1'h0, 13000, n);
    follow(m);
    check(m <= 16, 16'h1);
    act <= 1'h0;
    wait_for(rx_lock_lost, 1'h1, 9000, n);
    follow(m);
    check(m >= 48, 16'h1);
    host_mode <= 1'h1;
    settle();
    cc(2'h0, 16'h0000, 16'h0000, 5'h10, 16'h0090, 16'h0109);
    rreg(lineunit_pkg::STATUS_ADDR, d);
    check(d[0], 16'h1);
    final_report();
  end
endmodule
